// ==== verif/charger_status_event_flags_tb.sv ====
`timescale 1ns/10ps
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin \
    n_fail++; $display("Error at %0t: got %h want %h", $time, got, want); \
    end end
module charger_status_event_flags_tb;
    logic core_clk, sys_rst, reg_wr, reg_rd, irq_ff, rd_seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, want;
    logic [29:0] cond;
    logic [31:0] seed = 32'h0000_9c60;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int total_checks = 0;
    int i;
    int j;
    charger_status_event_flags i_charger_status_event_flags (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff),
        .end_of_charge(cond[0]), .battery_switch_on(cond[1]),
        .port_detect_done(cond[2]), .input_good_status(cond[3]),
        .charge_ready(cond[4]), .low_current_eoc(cond[5]),
        .background_charge(cond[6]),
        .min_input_voltage_loop_status(cond[7]),
        .input_current_loop_status(cond[8]),
        .thermal_loop_status(cond[9]), .bus_undervoltage_status(cond[10]),
        .safety_timeout_status(cond[11]),
        .system_overvoltage_status(cond[12]),
        .battery_overvoltage_status(cond[13]),
        .battery_hot_status(cond[14]), .battery_warm_status(cond[15]),
        .battery_cool_status(cond[16]), .battery_cold_status(cond[17]),
        .below_system_min_status(cond[18]), .system_short(cond[19]),
        .overtemp_status(cond[20]), .input_overvoltage_status(cond[21]),
        .watchdog_warning_status(cond[22]),
        .boost_const_current_status(cond[23]),
        .boost_low_battery(cond[24]), .boost_fault(cond[25]),
        .below_recharge_threshold(cond[26]), .bus_below_detach(cond[27]),
        .negotiation_done(cond[28]), .current_search_done(cond[29]));
    host_reg_port i_host_reg_port (.core_clk(core_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] status(input logic [29:0] c, input int k);
        case (k)
            0: return {c[3], c[4], c[5], c[6], c[0] & ~c[1], 2'b00, c[2]};
            1: return {c[7], c[8], c[9], c[10], c[11], c[12], c[13], 1'b0};
            2: return {c[14], c[15], c[16], c[17], 2'b00, c[18], 1'b0};
            default: return {c[20], c[21], c[22], 2'b00, c[23], 2'b00};
        endcase
    endfunction
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host_reg_port.xfer(1'b0, a, 8'h00);
    endtask
    // Set pulses are dropped after one cycle
    task automatic step(input int k, input logic v, input logic [7:0] a,
                        input logic [7:0] e);
        cond[k] <= v;
        @(posedge core_clk);
        if (k > 27) cond[k] <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(a, e);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) rd_seen <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_seen === 1'b1) begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
            `CHK(reg_rdata_ff, want)
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        sys_rst = 1'b1;
        cond = '0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            chk(8'h20 + i[7:0], 8'h00);
            chk(8'h30 + i[7:0], 8'hff);
        end
        chk(8'h40, 8'h00);
        i_host_reg_port.xfer(1'b1, 8'h31, 8'h00);
        i_host_reg_port.xfer(1'b1, 8'h33, 8'h00);
        i_host_reg_port.xfer(1'b1, 8'h11, 8'hff);
        chk(8'h31, 8'h01);
        chk(8'h33, 8'h18);
        for (i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            cond <= seed[29:0] & 30'h0fff_ffff;
            @(posedge core_clk);
            for (j = 0; j < 4; j++) begin
                chk(8'h10 | j[7:0], status(cond,j));
            end
        end
        cond <= '0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk(8'h31, 8'hff);
        chk(8'h21, 8'h00);
        i_host_reg_port.xfer(1'b1, 8'h31, 8'hdf);
        cond[9] <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(irq_ff, 1'b1)
        chk(8'h21, 8'h20);
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(irq_ff, 1'b0)
        step(9, 1'b0, 8'h21, 8'h00);
        step(14, 1'b1, 8'h22, 8'h80);
        #1;
        `CHK(irq_ff, 1'b0)
        step(2, 1'b1, 8'h20, 8'h01);
        step(18, 1'b1, 8'h22, 8'h02);
        step(19, 1'b1, 8'h22, 8'h01);
        step(28, 1'b1, 8'h22, 8'h08);
        step(29, 1'b1, 8'h22, 8'h04);
        step(23, 1'b1, 8'h23, 8'h04);
        step(24, 1'b1, 8'h23, 8'h02);
        step(25, 1'b1, 8'h23, 8'h01);
        step(0, 1'b1, 8'h20, 8'h08);
        step(26, 1'b1, 8'h20, 8'h04);
        step(3, 1'b1, 8'h20, 8'h80);
        step(3, 1'b0, 8'h20, 8'h00);
        step(27, 1'b1, 8'h20, 8'h02);
        chk(8'h23, 8'h00);
        chk(8'h10, 8'h09);
        repeat (3) @(posedge core_clk);
        end_of_test();
    end
endmodule // charger_status_event_flags_tb

// ==== verif/flags_checker_assertions.sv ====
`timescale 1ns/10ps
module flags_checker (
    input wire core_clk, // clk
    input wire sys_rst, // rst
    input wire reg_wr, // wr
    input wire reg_rd, // rd
    input wire [7:0] reg_addr, // addr
    input wire [7:0] reg_wdata, // wdata
    input wire [7:0] reg_rdata_ff, // rdata
    input wire irq_ff, // irq
    input wire end_of_charge, // eoc
    input wire battery_switch_on, // switch
    input wire port_detect_done, // detect
    input wire min_input_voltage_loop_status, // loop
    input wire input_current_loop_status, // loop
    input wire thermal_loop_status, // loop
    input wire overtemp_status, // temp
    input wire watchdog_warning_status // wdt
);
    reg thermal_mask_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always @(posedge core_clk) begin
        if (sys_rst) begin
            thermal_mask_ff <= 1'b1;
        end else if (reg_wr && reg_addr == 8'h31) begin
            thermal_mask_ff <= reg_wdata[5];
        end
    end
    a_done_status: assert property (reg_rd && reg_addr == 8'h10 |=>
        reg_rdata_ff[3] == $past(end_of_charge && !battery_switch_on))
        else $error("charge complete status wrong");
    a_port_status: assert property (reg_rd && reg_addr == 8'h10 |=>
        reg_rdata_ff[0] == $past(port_detect_done))
        else $error("port detect status wrong");
    a_loop_status: assert property (reg_rd && reg_addr == 8'h11 |=>
        reg_rdata_ff[7:5] == $past({min_input_voltage_loop_status,
        input_current_loop_status, thermal_loop_status}))
        else $error("loop status wrong");
    a_prot_status: assert property (reg_rd && reg_addr == 8'h13 |=>
        {reg_rdata_ff[7], reg_rdata_ff[5]} ==
        $past({overtemp_status, watchdog_warning_status}))
        else $error("protection status wrong");
    a_irq_raise: assert property (!thermal_mask_ff &&
        $rose(thermal_loop_status) |-> ##2 irq_ff)
        else $error("interrupt not raised");
    a_reset_idle: assert property ($fell(sys_rst) |->
        !irq_ff && reg_rdata_ff == 8'h00)
        else $error("outputs not idle after reset");
    a_mask_read: assert property (reg_rd && reg_addr == 8'h31 |=>
        reg_rdata_ff[0] && reg_rdata_ff[5] == $past(thermal_mask_ff))
        else $error("mask readback wrong");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data changed without read");
endmodule // flags_checker
bind charger_status_event_flags flags_checker i_flags_checker (.*);

// ==== verif/host_reg_port.sv ====
`timescale 1ns/10ps
module host_reg_port (
    input wire core_clk, // clock
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata // write data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released address and data lines invert and strobes drop to 0, so a stale value never passes
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // host_reg_port

// ==== verilog/charger_flags_map.vh ====
// Notes on behaviour
// - Charge-complete bit 3 is high only at end of charge, switch off.
// - Port-detect-done bit 0 and its flag rise when detection ends.
// - 0x11 bits 7..5 show the voltage, current and thermal loops live.
// - 0x11 bits 4..1 show bus UV, timeout, system and battery OV live.
// - 0x12 bits 7..4 show temperature zones, bit 1 below system minimum.
// - 0x13 shows over-temp bit 7, input OV bit 6, boost current bit 2.
// - Watchdog status reads 0 while counting, 1 as the reset warning.
// - Flags in 0x20..0x23 latch on a rising condition, clear on read.
// - Recharge flag sets when battery drops below threshold after charge.
// - Detach flag sets when input-good falls, then bus drops below limit.
// - 0x22 bits 3 and 2 flag negotiation and search done, clear on read.
// - 0x23 bits 2..0 flag boost current, low battery and boost fault.
// - 0x22 bit 0 flags system short beside the system-minimum bit 1.
// - Mask bits in 0x30..0x33 block their flag's irq, reset to 1 only.
`ifndef CHARGER_FLAGS_MAP_VH
`define CHARGER_FLAGS_MAP_VH

`define ADDR_STATUS0 8'h10
`define ADDR_STATUS1 8'h11
`define ADDR_STATUS2 8'h12
`define ADDR_STATUS3 8'h13
`define ADDR_FLAGS0 8'h20
`define ADDR_FLAGS1 8'h21
`define ADDR_FLAGS2 8'h22
`define ADDR_FLAGS3 8'h23
`define ADDR_EVENT_MASK_CHARGE_STATE 8'h30
`define ADDR_EVENT_MASK_REGULATION 8'h31
`define ADDR_EVENT_MASK_TEMPERATURE 8'h32
`define ADDR_MASK3 8'h33

// Writable mask bits per bank; reserved bits read as their reset value
`define EVENT_MASK_CHARGE_STATE_WR 8'hff
`define EVENT_MASK_REGULATION_WR 8'hfe
`define EVENT_MASK_TEMPERATURE_WR 8'hff
`define MASK3_WR 8'he7
`define MASK_RESET 8'hff

// Field positions
`define BIT_CHG_DONE 3
`define BIT_PORT_DONE 0
`define BIT_RECHG 2
`define BIT_DETACH 1
`define BIT_NEGOT 3
`define BIT_SEARCH 2
`define BIT_SYS_SHORT 0

`endif

// ==== verilog/charger_status_event_flags.v ====
`timescale 1ns/10ps
`include "charger_flags_map.vh"

module charger_status_event_flags (
    input wire core_clk, // 100 MHz core clock
    input wire sys_rst, // register reset, sync, high
    input wire reg_wr, // register write strobe
    input wire reg_rd, // register read strobe
    input wire [7:0] reg_addr, // register address
    input wire [7:0] reg_wdata, // write data
    output reg [7:0] reg_rdata_ff, // read data, registered
    output reg irq_ff, // interrupt, high active
    input wire end_of_charge, // end-of-charge state
    input wire battery_switch_on, // battery switch closed
    input wire port_detect_done, // port detection finished
    input wire input_good_status, // input source good
    input wire charge_ready, // input ready for charge
    input wire low_current_eoc, // below end current
    input wire background_charge, // background charging
    input wire min_input_voltage_loop_status, // loop active
    input wire input_current_loop_status, // loop active
    input wire thermal_loop_status, // loop active
    input wire bus_undervoltage_status, // bat < bus < 3.8V
    input wire safety_timeout_status, // safety time-out
    input wire system_overvoltage_status, // system OV
    input wire battery_overvoltage_status, // battery OV
    input wire battery_hot_status, // hot zone
    input wire battery_warm_status, // warm zone
    input wire battery_cool_status, // cool zone
    input wire battery_cold_status, // cold zone
    input wire below_system_min_status, // vbat < sys min
    input wire system_short, // system output short
    input wire overtemp_status, // over-temperature
    input wire input_overvoltage_status, // input OV
    input wire watchdog_warning_status, // watchdog near expiry
    input wire boost_const_current_status, // boost CC mode
    input wire boost_low_battery, // boost low battery
    input wire boost_fault, // boost fault
    input wire below_recharge_threshold, // vbat < recharge
    input wire bus_below_detach, // bus < bat or < 3.3V
    input wire negotiation_done, // negotiation done pulse
    input wire current_search_done // search done pulse
);
    // ------------------------------------------------------------
    // Status levels
    // ------------------------------------------------------------
    wire [7:0] st0;
    wire [7:0] st1;
    wire [7:0] st2;
    wire [7:0] st3;
    wire charge_complete_status;

    assign charge_complete_status = end_of_charge & ~battery_switch_on;
    assign st0 = {input_good_status, charge_ready, low_current_eoc,
                  background_charge, charge_complete_status, 2'b00,
                  port_detect_done};
    assign st1 = {min_input_voltage_loop_status, input_current_loop_status,
                  thermal_loop_status, bus_undervoltage_status,
                  safety_timeout_status, system_overvoltage_status,
                  battery_overvoltage_status, 1'b0};
    assign st2 = {battery_hot_status, battery_warm_status,
                  battery_cool_status, battery_cold_status, 2'b00,
                  below_system_min_status, 1'b0};
    assign st3 = {overtemp_status, input_overvoltage_status,
                  watchdog_warning_status, 2'b00,
                  boost_const_current_status, 2'b00};

    // ------------------------------------------------------------
    // Derived event sources
    // ------------------------------------------------------------
    reg eoc_seen_ff;
    reg detach_arm_ff;
    reg good_prev_ff;
    wire recharge_level;
    wire detach_pulse;

    // recharge only after end of charge
    always @(posedge core_clk) begin
        if (sys_rst)
            eoc_seen_ff <= 1'b0;
        else if (end_of_charge)
            eoc_seen_ff <= 1'b1;
        else if (~below_recharge_threshold)
            eoc_seen_ff <= eoc_seen_ff;
        else
            eoc_seen_ff <= 1'b0;
    end
    assign recharge_level = eoc_seen_ff & below_recharge_threshold;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            good_prev_ff <= 1'b0;
            detach_arm_ff <= 1'b0;
        end else begin
            good_prev_ff <= input_good_status;
            if (input_good_status)
                detach_arm_ff <= 1'b0;
            else if (good_prev_ff)
                detach_arm_ff <= 1'b1;
            else if (bus_below_detach)
                detach_arm_ff <= 1'b0;
        end
    end
    assign detach_pulse = detach_arm_ff & bus_below_detach &
                          ~input_good_status;

    // ------------------------------------------------------------
    // Event flag banks
    // ------------------------------------------------------------
    wire [7:0] lvl0;
    wire [7:0] lvl1;
    wire [7:0] lvl2;
    wire [7:0] lvl3;
    wire [7:0] pls0;
    wire [7:0] pls2;
    wire [7:0] fl0;
    wire [7:0] fl1;
    wire [7:0] fl2;
    wire [7:0] fl3;
    wire rd0;
    wire rd1;
    wire rd2;
    wire rd3;

    assign lvl0 = {st0[7:3], recharge_level, 1'b0, st0[0]};
    assign pls0 = {6'b00_0000, detach_pulse, 1'b0};
    assign lvl1 = st1;
    assign lvl2 = {st2[7:4], 2'b00, below_system_min_status, system_short};
    assign pls2 = {4'h0, negotiation_done, current_search_done, 2'b00};
    assign lvl3 = {st3[7:5], 2'b00, boost_const_current_status,
                   boost_low_battery, boost_fault};

    assign rd0 = reg_rd & (reg_addr == `ADDR_FLAGS0);
    assign rd1 = reg_rd & (reg_addr == `ADDR_FLAGS1);
    assign rd2 = reg_rd & (reg_addr == `ADDR_FLAGS2);
    assign rd3 = reg_rd & (reg_addr == `ADDR_FLAGS3);

    edge_flag_bank #(.WIDTH(8)) u_bank0 (
        .core_clk(core_clk), .sys_rst(sys_rst), .level_in(lvl0),
        .pulse_in(pls0), .valid_bits(8'hff), .read_clr(rd0),
        .flags(fl0));
    edge_flag_bank #(.WIDTH(8)) u_bank1 (
        .core_clk(core_clk), .sys_rst(sys_rst), .level_in(lvl1),
        .pulse_in(8'h00), .valid_bits(8'hfe), .read_clr(rd1),
        .flags(fl1));
    edge_flag_bank #(.WIDTH(8)) u_bank2 (
        .core_clk(core_clk), .sys_rst(sys_rst), .level_in(lvl2),
        .pulse_in(pls2), .valid_bits(8'hff), .read_clr(rd2),
        .flags(fl2));
    edge_flag_bank #(.WIDTH(8)) u_bank3 (
        .core_clk(core_clk), .sys_rst(sys_rst), .level_in(lvl3),
        .pulse_in(8'h00), .valid_bits(8'he7), .read_clr(rd3),
        .flags(fl3));

    // ------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------
    reg [7:0] event_mask_charge_state_ff;
    reg [7:0] event_mask_regulation_ff;
    reg [7:0] event_mask_temperature_ff;
    reg [7:0] mask3_ff;

    // masks reset to all ones
    // Only register reset touches them; watchdog reset is not an input
    always @(posedge core_clk) begin
        if (sys_rst) begin
            event_mask_charge_state_ff <= `MASK_RESET;
            event_mask_regulation_ff <= `MASK_RESET;
            event_mask_temperature_ff <= `MASK_RESET;
            mask3_ff <= `MASK_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_EVENT_MASK_CHARGE_STATE: event_mask_charge_state_ff <= (reg_wdata & `EVENT_MASK_CHARGE_STATE_WR) |
                                         (event_mask_charge_state_ff & ~`EVENT_MASK_CHARGE_STATE_WR);
                `ADDR_EVENT_MASK_REGULATION: event_mask_regulation_ff <= (reg_wdata & `EVENT_MASK_REGULATION_WR) |
                                         (event_mask_regulation_ff & ~`EVENT_MASK_REGULATION_WR);
                `ADDR_EVENT_MASK_TEMPERATURE: event_mask_temperature_ff <= (reg_wdata & `EVENT_MASK_TEMPERATURE_WR) |
                                         (event_mask_temperature_ff & ~`EVENT_MASK_TEMPERATURE_WR);
                `ADDR_MASK3: mask3_ff <= (reg_wdata & `MASK3_WR) |
                                         (mask3_ff & ~`MASK3_WR);
                default: event_mask_charge_state_ff <= event_mask_charge_state_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt and read path
    // ------------------------------------------------------------
    wire nxt_irq;
    reg [7:0] nxt_rdata;

    assign nxt_irq = |((fl0 & ~event_mask_charge_state_ff) | (fl1 & ~event_mask_regulation_ff) |
                       (fl2 & ~event_mask_temperature_ff) | (fl3 & ~mask3_ff));

    always @* begin
        case (reg_addr)
            `ADDR_STATUS0: nxt_rdata = st0;
            `ADDR_STATUS1: nxt_rdata = st1;
            `ADDR_STATUS2: nxt_rdata = st2;
            `ADDR_STATUS3: nxt_rdata = st3;
            `ADDR_FLAGS0: nxt_rdata = fl0;
            `ADDR_FLAGS1: nxt_rdata = fl1;
            `ADDR_FLAGS2: nxt_rdata = fl2;
            `ADDR_FLAGS3: nxt_rdata = fl3;
            `ADDR_EVENT_MASK_CHARGE_STATE: nxt_rdata = event_mask_charge_state_ff;
            `ADDR_EVENT_MASK_REGULATION: nxt_rdata = event_mask_regulation_ff;
            `ADDR_EVENT_MASK_TEMPERATURE: nxt_rdata = event_mask_temperature_ff;
            `ADDR_MASK3: nxt_rdata = mask3_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
            reg_rdata_ff <= 8'h00;
        end else begin
            irq_ff <= nxt_irq;
            if (reg_rd)
                reg_rdata_ff <= nxt_rdata;
        end
    end
endmodule // charger_status_event_flags

// ==== verilog/edge_flag_bank.v ====
`timescale 1ns/10ps
`include "charger_flags_map.vh"

module edge_flag_bank #(
    parameter WIDTH = 8
) (
    input wire core_clk, // core clock
    input wire sys_rst, // sync reset, high
    input wire [WIDTH-1:0] level_in, // condition levels
    input wire [WIDTH-1:0] pulse_in, // direct set pulses
    input wire [WIDTH-1:0] valid_bits, // implemented bits
    input wire read_clr, // host read of this bank
    output wire [WIDTH-1:0] flags // latched flags
);
    reg [WIDTH-1:0] prev_ff;
    reg [WIDTH-1:0] flag_ff;
    genvar i;

    always @(posedge core_clk) begin
        if (sys_rst)
            prev_ff <= {WIDTH{1'b0}};
        else
            prev_ff <= level_in;
    end

    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            wire set_now;
            assign set_now = valid_bits[i] &
                ((level_in[i] & ~prev_ff[i]) | pulse_in[i]);
            // edge latch, read clear
            // Set beats a same-cycle read clear so no event is lost
            always @(posedge core_clk) begin
                if (sys_rst)
                    flag_ff[i] <= 1'b0;
                else if (set_now)
                    flag_ff[i] <= 1'b1;
                else if (read_clr)
                    flag_ff[i] <= 1'b0;
            end
        end
    endgenerate

    assign flags = flag_ff;
endmodule // edge_flag_bank
